//--- pkg/smph_consts.vh
// Constants for the serial memory protect and hold controller.
// Included by the controller and its bench, not by the synchroniser; definitions only.
`ifndef SMPH_CONSTS_VH
`define SMPH_CONSTS_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SMPH_OP_RELEASE 8'hff
`define SMPH_OP_WREN 8'h06
`define SMPH_OP_WRDI 8'h04
`define SMPH_OP_STAT1_RD 8'h05
`define SMPH_OP_STAT1_WR 8'h01
`define SMPH_OP_STAT2_RD 8'h35
`define SMPH_OP_MEM_WR 8'h02
`define SMPH_OP_MEM_RD 8'h03
`define SMPH_OP_FAST_RD 8'h0b
`define SMPH_OP_DUAL_OUT_RD 8'h3b
`define SMPH_OP_DUAL_ADDR_RD 8'hbb
`define SMPH_OP_QUAD_OUT_RD 8'h6b
`define SMPH_OP_QUAD_ADDR_RD 8'heb
`define SMPH_OP_DUAL_WR 8'ha2
`define SMPH_OP_DUAL_ADDR_WR 8'ha1
`define SMPH_OP_QUAD_WR 8'h32
`define SMPH_OP_QUAD_ADDR_WR 8'h12
`define SMPH_OP_ENTER_QUAD 8'h38
`define SMPH_OP_ENTER_DUAL 8'h37

// ----------------------------------------------------------------
// Protect ranges and field positions
// ----------------------------------------------------------------
`define SMPH_ADDR_W 20
`define SMPH_BASE_QUARTER 20'hc0000
`define SMPH_BASE_HALF 20'h80000
`define SMPH_BASE_ALL 20'h00000
`define SMPH_BP_NONE 2'h0
`define SMPH_BP_QUARTER 2'h1
`define SMPH_BP_HALF 2'h2
`define SMPH_S2_DUAL_BIT 5
`define SMPH_S2_QUAD_BIT 6
`define SMPH_OP_BITS 8
`define SMPH_CNT_W 6
`define SMPH_LEN_QUAD 6'h02
`define SMPH_LEN_DUAL 6'h04
`define SMPH_LEN_SINGLE 6'h08

`endif

//--- logic/smph_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes all inputs are asynchronous to clk_in.
`timescale 1ns/1ps
module smph_sync #(
  parameter WIDTH = 4
) (
  input wire clk_in,
  input wire rst_in,
  input wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  genvar i;
  // ----------------------------------------------------------------
  // Per-bit double flop
  // ----------------------------------------------------------------
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_in) begin
        if (rst_in) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= d_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate
  assign q_out = sync_r;
endmodule

//--- logic/smph_ctrl.v
// Mode release, block protect, write gating and hold for a serial memory.
// Assumes the host SPI pins arrive asynchronously; SCK is oversampled.
// Behaviour
// - Release opcode returns to single-wire, clears dual/quad flags
// - Release opcode is all ones, both modes
// - Status two bits mirror dual/quad mode
// - Two protect bits select protected range
// - Latch clear refuses every write
// - Range and guard/pin gate writes
// - Hold low suspends command, keeps progress
// - Hold ignores clock and data lines
// - Hold floats output during read commands
// - Select rising in hold aborts command
// - Early abort keeps write latch value
// - Hold ignored in quad commands and mode
`timescale 1ns/1ps
`include "smph_consts.vh"
module smph_ctrl #(
  parameter ADDR_W = `SMPH_ADDR_W
) (
  input wire MCLK_IN,
  input wire SYS_RST_IN,
  input wire SCK_IN,
  input wire CS_N_IN,
  input wire HOLD_N_IN,
  input wire WP_N_IN,
  input wire [3:0] IO_IN,
  input wire [1:0] RANGE_GUARD_IN,
  input wire STATUS_GUARD_ENABLE_IN,
  input wire [ADDR_W-1:0] WRITE_ADDR_IN,
  input wire ADDR_VALID_IN,
  input wire SO_DATA_IN,
  output reg SO_OUT,
  output reg SO_OE_N_OUT,
  output reg DUAL_WIRE_CMD_MODE_OUT,
  output reg QUAD_WIRE_CMD_MODE_OUT,
  output wire [7:0] STATUS_TWO_OUT,
  output reg WRITE_LATCH_FLAG_OUT,
  output reg [7:0] OPCODE_OUT,
  output reg OPCODE_VALID_OUT,
  output reg HOLD_ACTIVE_OUT,
  output reg ABORT_OUT,
  output reg MEM_WRITE_OK_OUT,
  output reg STATUS_WRITE_OK_OUT,
  output reg SHIFT_EN_OUT
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  wire [7:0] pins_s;
  smph_sync #(.WIDTH(8)) smph_sync_inst (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in({IO_IN, WP_N_IN, HOLD_N_IN, CS_N_IN, SCK_IN}),
    .q_out(pins_s)
  );
  wire sck_s = pins_s[0];
  wire cs_n_s = pins_s[1];
  wire hold_n_s = pins_s[2];
  wire wp_n_s = pins_s[3];
  wire [3:0] io_s = pins_s[7:4];

  // ----------------------------------------------------------------
  // State and decode nets
  // ----------------------------------------------------------------
  reg sck_d_r;
  reg cs_d_r;
  reg hold_r;
  reg hold_sck_r;
  reg [7:0] sh_r;
  reg [`SMPH_CNT_W-1:0] cnt_r;
  reg op_done_r;
  reg [7:0] op_r;
  reg wel_save_r;
  reg sck_rise;
  reg [7:0] sh_nxt;
  reg [`SMPH_CNT_W-1:0] cnt_nxt;
  reg [`SMPH_CNT_W-1:0] op_len;
  reg is_read;
  reg is_quad_cmd;
  reg is_mem_wr;
  reg in_range;
  reg is_stat_wr;
  reg hold_off;
  reg hold_go;
  reg hold_end;
  reg shift_go;
  reg cs_rise;
  reg dual_nxt;
  reg quad_nxt;
  reg wel_nxt;
  reg mem_ok_nxt;
  reg stat_ok_nxt;
  reg oe_n_nxt;
  reg [7:0] stat_two;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  always @* begin
    sck_rise = sck_s & ~sck_d_r;
    if (QUAD_WIRE_CMD_MODE_OUT)
      op_len = `SMPH_LEN_QUAD;
    else if (DUAL_WIRE_CMD_MODE_OUT)
      op_len = `SMPH_LEN_DUAL;
    else
      op_len = `SMPH_LEN_SINGLE;
    if (QUAD_WIRE_CMD_MODE_OUT)
      sh_nxt = {sh_r[3:0], io_s};
    else if (DUAL_WIRE_CMD_MODE_OUT)
      sh_nxt = {sh_r[5:0], io_s[1:0]};
    else
      sh_nxt = {sh_r[6:0], io_s[0]};
    cnt_nxt = cnt_r + `SMPH_CNT_W'h1;
    case (op_r)
      `SMPH_OP_STAT1_RD, `SMPH_OP_STAT2_RD, `SMPH_OP_MEM_RD, `SMPH_OP_FAST_RD,
      `SMPH_OP_DUAL_OUT_RD, `SMPH_OP_DUAL_ADDR_RD: is_read = op_done_r;
      default: is_read = 1'b0;
    endcase
    case (op_r)
      `SMPH_OP_QUAD_OUT_RD, `SMPH_OP_QUAD_ADDR_RD, `SMPH_OP_QUAD_WR,
      `SMPH_OP_QUAD_ADDR_WR: is_quad_cmd = op_done_r;
      default: is_quad_cmd = 1'b0;
    endcase
    case (op_r)
      `SMPH_OP_MEM_WR, `SMPH_OP_DUAL_WR, `SMPH_OP_DUAL_ADDR_WR, `SMPH_OP_QUAD_WR,
      `SMPH_OP_QUAD_ADDR_WR: is_mem_wr = op_done_r;
      default: is_mem_wr = 1'b0;
    endcase
    case (op_r)
      `SMPH_OP_STAT1_WR: is_stat_wr = op_done_r;
      default: is_stat_wr = 1'b0;
    endcase
    case (RANGE_GUARD_IN)
      `SMPH_BP_NONE: in_range = 1'b0;
      `SMPH_BP_QUARTER: in_range = (WRITE_ADDR_IN >= `SMPH_BASE_QUARTER);
      `SMPH_BP_HALF: in_range = (WRITE_ADDR_IN >= `SMPH_BASE_HALF);
      default: in_range = (WRITE_ADDR_IN >= `SMPH_BASE_ALL);
    endcase
  end

  // ----------------------------------------------------------------
  // Status register two
  // ----------------------------------------------------------------
  always @* begin
    stat_two = 8'h00;
    stat_two[`SMPH_S2_DUAL_BIT] = DUAL_WIRE_CMD_MODE_OUT;
    stat_two[`SMPH_S2_QUAD_BIT] = QUAD_WIRE_CMD_MODE_OUT;
  end
  assign STATUS_TWO_OUT = stat_two;

  // ----------------------------------------------------------------
  // Hold qualification and frame end
  // ----------------------------------------------------------------
  always @* begin
    hold_off = QUAD_WIRE_CMD_MODE_OUT | is_quad_cmd;
    hold_go = ~hold_r & ~hold_n_s & ~hold_off;
    hold_end = hold_r & hold_n_s & (sck_s == hold_sck_r);
    shift_go = ~hold_r & (hold_n_s | hold_off) & sck_rise;
    cs_rise = cs_n_s & ~cs_d_r;
  end

  // ----------------------------------------------------------------
  // Mode and write latch update at select rising
  // ----------------------------------------------------------------
  always @* begin
    dual_nxt = DUAL_WIRE_CMD_MODE_OUT;
    quad_nxt = QUAD_WIRE_CMD_MODE_OUT;
    wel_nxt = WRITE_LATCH_FLAG_OUT;
    // Abort restores the latch; a finished opcode takes effect
    if (cs_rise && hold_r) begin
      if (!op_done_r)
        wel_nxt = wel_save_r;
    end else if (cs_rise && op_done_r) begin
      case (op_r)
        `SMPH_OP_RELEASE: begin
          dual_nxt = 1'b0;
          quad_nxt = 1'b0;
        end
        `SMPH_OP_ENTER_QUAD: begin
          quad_nxt = 1'b1;
          dual_nxt = 1'b0;
        end
        `SMPH_OP_ENTER_DUAL: begin
          dual_nxt = 1'b1;
          quad_nxt = 1'b0;
        end
        `SMPH_OP_WREN: wel_nxt = 1'b1;
        `SMPH_OP_WRDI: wel_nxt = 1'b0;
        default: wel_nxt = WRITE_LATCH_FLAG_OUT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Hold state
  // ----------------------------------------------------------------
  always @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      hold_r <= 1'b0;
      hold_sck_r <= 1'b0;
      wel_save_r <= 1'b0;
      HOLD_ACTIVE_OUT <= 1'b0;
    end else if (cs_n_s) begin
      hold_r <= 1'b0;
      HOLD_ACTIVE_OUT <= 1'b0;
    end else if (hold_go) begin
      hold_r <= 1'b1;
      hold_sck_r <= sck_s;
      wel_save_r <= WRITE_LATCH_FLAG_OUT;
      HOLD_ACTIVE_OUT <= 1'b1;
    end else if (hold_end) begin
      hold_r <= 1'b0;
      HOLD_ACTIVE_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shifter, opcode and mode registers
  // ----------------------------------------------------------------
  always @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      sck_d_r <= 1'b1;
      cs_d_r <= 1'b1;
      sh_r <= 8'h00;
      cnt_r <= {`SMPH_CNT_W{1'b0}};
      op_done_r <= 1'b0;
      op_r <= 8'h00;
      DUAL_WIRE_CMD_MODE_OUT <= 1'b0;
      QUAD_WIRE_CMD_MODE_OUT <= 1'b0;
      WRITE_LATCH_FLAG_OUT <= 1'b0;
      OPCODE_OUT <= 8'h00;
      OPCODE_VALID_OUT <= 1'b0;
      ABORT_OUT <= 1'b0;
      SHIFT_EN_OUT <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
      DUAL_WIRE_CMD_MODE_OUT <= dual_nxt;
      QUAD_WIRE_CMD_MODE_OUT <= quad_nxt;
      WRITE_LATCH_FLAG_OUT <= wel_nxt;
      OPCODE_VALID_OUT <= 1'b0;
      ABORT_OUT <= cs_rise & hold_r;
      SHIFT_EN_OUT <= 1'b0;
      if (cs_n_s) begin
        // Select high ends or aborts the command; progress resets
        cnt_r <= {`SMPH_CNT_W{1'b0}};
        op_done_r <= 1'b0;
        op_r <= 8'h00;
      end else if (shift_go) begin
        SHIFT_EN_OUT <= op_done_r;
        if (!op_done_r) begin
          // Quad mode takes two clocks of four bits each
          sh_r <= sh_nxt;
          cnt_r <= cnt_nxt;
          if (cnt_nxt == op_len) begin
            op_done_r <= 1'b1;
            op_r <= sh_nxt;
            OPCODE_OUT <= sh_nxt;
            OPCODE_VALID_OUT <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Write gating and serial output
  // ----------------------------------------------------------------
  always @* begin
    mem_ok_nxt = WRITE_LATCH_FLAG_OUT & is_mem_wr & ADDR_VALID_IN & ~in_range & ~hold_r &
                 ~cs_n_s;
    stat_ok_nxt = WRITE_LATCH_FLAG_OUT & is_stat_wr & ~hold_r & ~cs_n_s &
                  ~(STATUS_GUARD_ENABLE_IN & ~wp_n_s);
    oe_n_nxt = ~(is_read & ~hold_r & ~cs_n_s);
  end

  always @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      MEM_WRITE_OK_OUT <= 1'b0;
      STATUS_WRITE_OK_OUT <= 1'b0;
      SO_OUT <= 1'b0;
      SO_OE_N_OUT <= 1'b1;
    end else begin
      MEM_WRITE_OK_OUT <= mem_ok_nxt;
      STATUS_WRITE_OK_OUT <= stat_ok_nxt;
      SO_OUT <= SO_DATA_IN;
      SO_OE_N_OUT <= oe_n_nxt;
    end
  end
endmodule

//--- dv/smph_monitor.sv
// Checker of protect and hold relations at the controller ports.
// Bound into every smph_ctrl instance; sees its ports only.
`timescale 1ns/1ps
module smph_monitor (
  input wire MCLK_IN,
  input wire SYS_RST_IN,
  input wire WP_N_IN,
  input wire [1:0] RANGE_GUARD_IN,
  input wire STATUS_GUARD_ENABLE_IN,
  input wire SO_OE_N_OUT,
  input wire DUAL_WIRE_CMD_MODE_OUT,
  input wire QUAD_WIRE_CMD_MODE_OUT,
  input wire [7:0] STATUS_TWO_OUT,
  input wire WRITE_LATCH_FLAG_OUT,
  input wire HOLD_ACTIVE_OUT,
  input wire ABORT_OUT,
  input wire MEM_WRITE_OK_OUT,
  input wire STATUS_WRITE_OK_OUT,
  input wire SHIFT_EN_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence held_s;
    HOLD_ACTIVE_OUT ##1 HOLD_ACTIVE_OUT;
  endsequence
  so_float_a: assert property (held_s |-> SO_OE_N_OUT)
    else $error("SO driven in hold");
  shift_stop_a: assert property (held_s |-> !SHIFT_EN_OUT)
    else $error("shift in hold");
  abort_cause_a: assert property (ABORT_OUT |-> $past(HOLD_ACTIVE_OUT))
    else $error("abort outside hold");
  mode_bits_a: assert property (STATUS_TWO_OUT ==
    {1'b0, QUAD_WIRE_CMD_MODE_OUT, DUAL_WIRE_CMD_MODE_OUT, 5'h00}) else $error("bad status two");
  latch_gate_a: assert property (!WRITE_LATCH_FLAG_OUT ##1 !WRITE_LATCH_FLAG_OUT |->
    !MEM_WRITE_OK_OUT && !STATUS_WRITE_OK_OUT) else $error("write with latch clear");
  guard_pin_a: assert property ((STATUS_GUARD_ENABLE_IN && !WP_N_IN) [*5] |->
    !STATUS_WRITE_OK_OUT) else $error("guarded status write");
  range_all_a: assert property ((RANGE_GUARD_IN == 2'h3) [*3] |-> !MEM_WRITE_OK_OUT)
    else $error("write in full protect");
  quad_hold_a: assert property ($rose(HOLD_ACTIVE_OUT) |-> !QUAD_WIRE_CMD_MODE_OUT)
    else $error("hold in quad mode");
endmodule
bind smph_ctrl smph_monitor smph_monitor_inst (.*);

//--- dv/smph_host.sv
// Host model: drives select, serial clock, hold and IO pins.
// Paced by the system clock; SCK idles low between frames.
`timescale 1ns/1ps
module smph_host (
  input wire clk_in,
  output reg sck_out,
  output reg cs_n_out,
  output reg hold_n_out,
  output reg [3:0] io_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    hold_n_out = 1'b1;
    io_out = 4'h0;
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  // Bit 0 of f opens the frame, bit 1 closes it; half SCK period is 4 clocks
  task put(input [7:0] v, input integer n, input integer w, input [1:0] f);
    integer i;
    begin
      if (f[0]) cs_n_out = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        if (w == 4) io_out = v[7:4];
        else if (w == 2) io_out[1:0] = v[7:6];
        else io_out[0] = v[7];
        v = v << w;
        tick(4);
        sck_out = 1'b1;
        tick(4);
        sck_out = 1'b0;
      end
      tick(4);
      if (f[1]) begin
        io_out = ~io_out;
        cs_n_out = 1'b1;
        tick(8);
      end
    end
  endtask
  // Even k toggles leave SCK low again before hold is released
  task pause(input integer k, input ab);
    integer i;
    begin
      hold_n_out = 1'b0;
      tick(6);
      for (i = 0; i < k; i = i + 1) begin
        sck_out = ~sck_out;
        tick(4);
      end
      if (ab) begin
        io_out = ~io_out;
        cs_n_out = 1'b1;
        tick(6);
      end
      hold_n_out = 1'b1;
      tick(4);
    end
  endtask
endmodule

//--- dv/smph_ctrl_tb.sv
// Self-checking bench for the protect and hold controller.
// Host pins come from smph_host; datapath inputs driven here.
`timescale 1ns/1ps
`include "smph_consts.vh"
module smph_ctrl_tb;
  reg clk, rst, wp_n, ge, av, hseen, aseen, hclr, sod;
  reg [7:0] vcnt, scnt;
  reg [1:0] rg;
  reg [19:0] addr;
  wire sck, cs_n, hold_n, so, oe_n, dual, quad, write_latch_flag, opv, hact, abrt, mok, sok, shf;
  wire [3:0] io;
  wire [7:0] s2, op;
  integer fails, tests_run, k;
  smph_ctrl smph_ctrl_inst (.MCLK_IN(clk), .SYS_RST_IN(rst), .SCK_IN(sck), .CS_N_IN(cs_n),
    .HOLD_N_IN(hold_n), .WP_N_IN(wp_n), .IO_IN(io), .RANGE_GUARD_IN(rg),
    .STATUS_GUARD_ENABLE_IN(ge), .WRITE_ADDR_IN(addr), .ADDR_VALID_IN(av), .SO_DATA_IN(sod),
    .SO_OUT(so), .SO_OE_N_OUT(oe_n), .DUAL_WIRE_CMD_MODE_OUT(dual),
    .QUAD_WIRE_CMD_MODE_OUT(quad), .STATUS_TWO_OUT(s2), .WRITE_LATCH_FLAG_OUT(write_latch_flag),
    .OPCODE_OUT(op), .OPCODE_VALID_OUT(opv), .HOLD_ACTIVE_OUT(hact), .ABORT_OUT(abrt),
    .MEM_WRITE_OK_OUT(mok), .STATUS_WRITE_OK_OUT(sok), .SHIFT_EN_OUT(shf));
  smph_host smph_host_inst (.clk_in(clk), .sck_out(sck), .cs_n_out(cs_n),
    .hold_n_out(hold_n), .io_out(io));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (hclr) begin
      {hseen, aseen, vcnt, scnt} <= 18'h0;
    end else begin
      if (hact === 1'b1) hseen <= 1'b1;
      if (abrt === 1'b1) aseen <= 1'b1;
      if (opv === 1'b1) vcnt <= vcnt + 8'h1;
      if (shf === 1'b1) scnt <= scnt + 8'h1;
    end
  end
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input string n, input [19:0] seen, input [19:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      if (fails == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task clr;
    begin
      hclr = 1'b1;
      tick(1);
      hclr = 1'b0;
    end
  endtask
  task sp(input [7:0] v, input integer n, input integer w, input [1:0] f);
    smph_host_inst.put(v, n, w, f);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    fails = fails + 1;
    stop_test;
  end
  initial begin
    {rst, wp_n, ge, av, hclr, sod, rg, addr} = {6'h38, 2'h0, 20'h00000};
    fails = 0;
    tests_run = 0;
    tick(20);
    {rst, hclr} = 2'h0;
    tick(4);
    sp(`SMPH_OP_WREN, 8, 1, 2'h3);
    chk("latch set", write_latch_flag, 20'h1);
    sp(`SMPH_OP_MEM_WR, 8, 1, 2'h1);
    av = 1'b1;
    for (k = 0; k < 16; k = k + 1) begin
      rg = k[3:2];
      addr = (k[1:0] == 0) ? `SMPH_BASE_ALL : (k[1:0] == 1) ? `SMPH_BASE_HALF - 20'h1 :
        (k[1:0] == 2) ? `SMPH_BASE_QUARTER - 20'h1 : `SMPH_BASE_QUARTER;
      ge = k[0] ^ k[2];
      wp_n = k[1];
      tick(6);
      chk("mem ok", mok, rg == 0 || (rg == 1 && addr < `SMPH_BASE_QUARTER) ||
        (rg == 2 && addr < `SMPH_BASE_HALF));
      chk("status ok", sok, 20'h0);
    end
    sp(8'h00, 0, 1, 2'h2);
    {av, rg} = 3'h0;
    sp(`SMPH_OP_STAT1_WR, 8, 1, 2'h1);
    for (k = 0; k < 4; k = k + 1) begin
      ge = k[0];
      wp_n = k[1];
      tick(6);
      chk("status ok", sok, !(ge && !wp_n));
    end
    sp(8'h00, 0, 1, 2'h2);
    sp(`SMPH_OP_WRDI, 8, 1, 2'h3);
    sp(`SMPH_OP_MEM_WR, 8, 1, 2'h1);
    av = 1'b1;
    tick(6);
    chk("refused", {mok, sok}, 20'h0);
    sp(8'h00, 0, 1, 2'h2);
    sp(`SMPH_OP_STAT1_WR, 8, 1, 2'h1);
    tick(6);
    chk("status refused", sok, 20'h0);
    sp(8'h00, 0, 1, 2'h2);
    sp(`SMPH_OP_WREN, 8, 1, 2'h3);
    chk("next cmd", write_latch_flag, 20'h1);
    sp(`SMPH_OP_ENTER_DUAL, 8, 1, 2'h3);
    chk("dual flag", s2, 20'h20);
    sp(`SMPH_OP_RELEASE, 4, 2, 2'h3);
    chk("dual off", s2, 20'h0);
    sp(`SMPH_OP_ENTER_QUAD, 8, 1, 2'h3);
    chk("quad flag", s2, 20'h40);
    clr;
    sp(8'h00, 0, 1, 2'h1);
    smph_host_inst.pause(0, 1'b0);
    sp(`SMPH_OP_RELEASE, 2, 4, 2'h2);
    chk("quad hold", hseen, 20'h0);
    chk("quad off", {dual, quad, s2}, 20'h0);
    clr;
    sp(`SMPH_OP_STAT1_RD, 4, 1, 2'h1);
    smph_host_inst.pause(4, 1'b0);
    sp(`SMPH_OP_STAT1_RD << 4, 4, 1, 2'h0);
    chk("held", hseen, 20'h1);
    chk("opcode", op, `SMPH_OP_STAT1_RD);
    chk("so drive", oe_n, 20'h0);
    chk("opcode pulses", vcnt, 20'h1);
    sod = 1'b1;
    smph_host_inst.pause(4, 1'b0);
    sp(8'h00, 2, 1, 2'h0);
    chk("data shifts", scnt, 20'h2);
    chk("so data", so, 20'h1);
    sp(8'h00, 0, 1, 2'h2);
    clr;
    sp(`SMPH_OP_WRDI, 3, 1, 2'h1);
    smph_host_inst.pause(2, 1'b1);
    chk("abort", aseen, 20'h1);
    chk("latch kept", write_latch_flag, 20'h1);
    stop_test;
  end
endmodule
